// >>> serial_dac_load_interface.sv
// Purpose: Serial input port and latch of a 12-bit signed DAC.
// Assumes: Link clock well below clk/4; pins sampled by clk.
// Notes: Edges of the link lines are found in the clk domain.
`timescale 1ns/1ps
`include "dac_load_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module serial_dac_load_interface
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic serial_word_in,
  input wire logic sync_n,
  input wire logic latch_load_n,
  output logic signed [`CODE_BITS-1:0] dac_code,
  output logic signed [31:0] dac_microvolt,
  output logic latch_update,
  output logic auto_mode
);
  dac_load_pkg::link_pins_type pins_raw;
  dac_load_pkg::link_pins_type pins;
  dac_load_pkg::link_pins_type pins_prev_q, pins_prev_d;
  dac_load_pkg::frame_state_type state_q, state_d;
  logic [`WORD_BITS-1:0] shift_q, shift_d;
  logic [`BIT_COUNT_W-1:0] count_q, count_d;
  logic signed [`CODE_BITS-1:0] latch_q, latch_d;
  logic signed [31:0] microvolt_q, microvolt_d;
  logic auto_q, auto_d;
  logic done_q, done_d;
  logic update_q, update_d;
  logic sclk_fall;
  logic sync_fall;
  logic load_fall;
  logic bit_take;
  logic last_bit;
  logic auto_load;
  logic cmd_load;
  logic [`WORD_BITS-1:0] next_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Link pins pass two flip-flops before any logic reads them.
  function automatic logic fell(input logic was_level, input logic cur_level);
    fell = was_level && !cur_level;
  endfunction

  assign pins_raw = '{
    sclk: sclk,
    serial_word_in: serial_word_in,
    sync_n: sync_n,
    latch_load_n: latch_load_n
  };
  pin_sync pin_sync_inst
  (
    .clk(clk),
    .arst_n(arst_n),
    .pins_async(pins_raw),
    .pins_sync(pins)
  );

  always_comb
  begin
    pins_prev_d = pins;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_prev_q <= `PINS_RESET;
    end
    else
    begin
      pins_prev_q <= pins_prev_d;
    end
  end

  assign sclk_fall = fell(pins_prev_q.sclk, pins.sclk);
  assign sync_fall = fell(pins_prev_q.sync_n, pins.sync_n);
  assign load_fall = fell(pins_prev_q.latch_load_n, pins.latch_load_n);
  assign next_word = {shift_q[`WORD_BITS-2:0], pins.serial_word_in};

  ////////////////////////////////////////////////////////////////////////////////
  // Load decisions shared by the frame and latch groups.
  assign bit_take = !sync_fall && state_q == dac_load_pkg::shift_st && !pins.sync_n && sclk_fall
    && count_q != `LAST_BIT_COUNT;
  assign last_bit = bit_take && count_q == `LAST_BIT_COUNT - 5'h01;
  assign auto_load = last_bit && auto_q;
  assign cmd_load = !sync_fall && !auto_q && done_q && load_fall;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame control and shift register.
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    count_d = count_q;
    auto_d = auto_q;
    done_d = done_q;
    if (sync_fall)
    begin
      state_d = dac_load_pkg::shift_st;
      count_d = '0;
      done_d = 1'b0;
      auto_d = !pins.latch_load_n;
    end
    else
    begin
      unique case (state_q)
        dac_load_pkg::idle_st:
        begin
          state_d = dac_load_pkg::idle_st;
        end
        dac_load_pkg::shift_st:
        begin
          if (pins.sync_n)
          begin
            state_d = (done_q && !auto_q) ? dac_load_pkg::wait_load_st : dac_load_pkg::idle_st;
          end
          else if (bit_take)
          begin
            shift_d = next_word;
            count_d = count_q + 5'h01;
            if (last_bit)
            begin
              done_d = 1'b1;
            end
          end
        end
        dac_load_pkg::wait_load_st:
        begin
          state_d = dac_load_pkg::wait_load_st;
        end
        default:
        begin
          state_d = dac_load_pkg::idle_st;
        end
      endcase
      if (cmd_load)
      begin
        done_d = 1'b0;
        if (state_q == dac_load_pkg::wait_load_st)
        begin
          state_d = dac_load_pkg::idle_st;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= dac_load_pkg::idle_st;
      shift_q <= `SHIFT_RESET;
      count_q <= `COUNT_RESET;
      auto_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      count_q <= count_d;
      auto_q <= auto_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The latch is written only on an automatic or a commanded load.
  always_comb
  begin
    latch_d = latch_q;
    update_d = 1'b0;
    if (auto_load)
    begin
      latch_d = next_word[`CODE_BITS-1:0];
      update_d = 1'b1;
    end
    else if (cmd_load)
    begin
      latch_d = shift_q[`CODE_BITS-1:0];
      update_d = 1'b1;
    end
    microvolt_d = 32'(int'(latch_d) * (`STEP_MICROVOLT_NUM / `STEP_DENOM));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_q <= `LATCH_RESET;
      microvolt_q <= `MICROVOLT_RESET;
      update_q <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      microvolt_q <= microvolt_d;
      update_q <= update_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs: signed code, its nominal level in microvolts, the update pulse and the mode flag.
  assign dac_code = latch_q;
  assign dac_microvolt = microvolt_q;
  assign latch_update = update_q;
  assign auto_mode = auto_q;
endmodule

// >>> dac_load_defs.svh
// Purpose: Constants of the serial DAC load interface.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef DAC_LOAD_DEFS_SVH
`define DAC_LOAD_DEFS_SVH
`define WORD_BITS 16
`define CODE_BITS 12
`define DONT_CARE_BITS 4
`define BIT_COUNT_W 5
`define LAST_BIT_COUNT 5'h10
`define LATCH_RESET 12'h000
`define PINS_RESET 4'hf
`define SHIFT_RESET 16'h0000
`define COUNT_RESET 5'h00
`define MICROVOLT_RESET 32'h00000000
`define STEP_MICROVOLT_NUM 5000000
`define STEP_DENOM 2048
`endif

// >>> dac_load_pkg.sv
// Purpose: Types of the serial DAC load interface.
// Assumes: Constants come from dac_load_defs.svh.
// Notes: Pin groups travel as packed structs.
`include "dac_load_defs.svh"
package dac_load_pkg;
  typedef struct packed
  {
    logic sclk;
    logic serial_word_in;
    logic sync_n;
    logic latch_load_n;
  } link_pins_type;
  typedef enum logic [1:0]
  {
    idle_st,
    shift_st,
    wait_load_st
  } frame_state_type;
endpackage

// >>> pin_sync.sv
// Purpose: Two-flop synchroniser for the link pins.
// Assumes: Pins are asynchronous to clk.
// Notes: Only the second stage is read outside.
`timescale 1ns/1ps
`include "dac_load_defs.svh"
module pin_sync
(
  input wire logic clk,
  input wire logic arst_n,
  input wire dac_load_pkg::link_pins_type pins_async,
  output dac_load_pkg::link_pins_type pins_sync
);
  dac_load_pkg::link_pins_type stage1_q;
  dac_load_pkg::link_pins_type stage2_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_q <= `PINS_RESET;
      stage2_q <= `PINS_RESET;
    end
    else
    begin
      stage1_q <= pins_async;
      stage2_q <= stage1_q;
    end
  end
  assign pins_sync = stage2_q;
endmodule

// >>> serial_dac_load_interface_asserts.sv
// Purpose: Link checks.
// Assumes: Slow link.
// Notes: Bound below.
`timescale 1ns/1ps
module serial_dac_load_interface_asserts
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic serial_word_in,
  input wire logic sync_n,
  input wire logic latch_load_n,
  input wire logic signed [11:0] dac_code,
  input wire logic signed [31:0] dac_microvolt,
  input wire logic latch_update,
  input wire logic auto_mode
);
  logic [4:0] cnt_q, cnt_d;
  logic [1:0] pv_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_comb
  begin
    cnt_d = cnt_q;
    if (pv_q[1] && !sync_n)
      cnt_d = 5'h00;
    else if (pv_q[0] && !sclk && !sync_n)
      cnt_d = cnt_q + 5'h01;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 5'h00;
      pv_q <= 2'h3;
    end
    else
    begin
      cnt_q <= cnt_d;
      pv_q <= {sync_n, sclk};
    end
  end
  a_code_holds: assert property ($changed(dac_code) |-> latch_update) else $error("bad");
  a_volt_scale: assert property (dac_microvolt == 32'(dac_code) * 32'sd2441) else $error("bad");
  a_pulse_one: assert property (latch_update |=> !latch_update) else $error("bad");
  a_auto_pick: assert property ($fell(sync_n) && !latch_load_n |-> ##[1:5] auto_mode) else $error("bad");
  a_cmd_pick: assert property ($fell(sync_n) && latch_load_n |-> ##[1:5] !auto_mode) else $error("bad");
  a_auto_count: assert property (latch_update && auto_mode |-> cnt_q == 5'h10) else $error("bad");
  a_cmd_load: assert property (latch_update && !auto_mode |-> !latch_load_n && cnt_q >= 5'h10) else $error("bad");
  a_mode_frame: assert property ($changed(auto_mode) |-> !sync_n) else $error("bad");
endmodule
bind serial_dac_load_interface serial_dac_load_interface_asserts serial_dac_load_interface_asserts_inst
(
  .clk(clk),
  .arst_n(arst_n),
  .sclk(sclk),
  .serial_word_in(serial_word_in),
  .sync_n(sync_n),
  .latch_load_n(latch_load_n),
  .dac_code(dac_code),
  .dac_microvolt(dac_microvolt),
  .latch_update(latch_update),
  .auto_mode(auto_mode)
);

// >>> dac_host_model.sv
// Purpose: Host port.
// Assumes: 48 ns link.
// Notes: Clock idles low.
`timescale 1ns/1ps
module dac_host_model
(
  output logic sclk = 1'b0,
  output logic serial_word_in = 1'b1,
  output logic sync_n = 1'b1,
  output logic latch_load_n = 1'b1
);
  task automatic send(input logic [15:0] w, input int n, input bit cmd, input int x);
    latch_load_n = cmd;
    #24 sync_n = 1'b0;
    for (int i = 0; i < n + x; i++)
    begin
      #24 sclk = 1'b1;
      serial_word_in = i < 16 ? w[15 - i] : ~serial_word_in;
      #24 sclk = 1'b0;
      if (i == 7)
        #96;
    end
    #48 sync_n = 1'b1;
    serial_word_in = ~serial_word_in;
    if (cmd)
    begin
      #48 latch_load_n = 1'b0;
      #48 latch_load_n = 1'b1;
    end
    #48;
  endtask
endmodule

// >>> serial_dac_load_interface_tb.sv
// Purpose: Bench.
// Assumes: Host model.
// Notes: Queue of codes.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t %h %h", $time, a, b); end end
module serial_dac_load_interface_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, serial_word_in, sync_n, latch_load_n, latch_update, auto_mode;
  logic signed [11:0] dac_code;
  logic signed [31:0] dac_microvolt;
  logic [11:0] c;
  logic [12:0] q[$];
  logic [15:0] rnd = 16'h03b7;
  logic [11:0] t [6] = '{12'h7ff, 12'h001, 12'h000, 12'hfff, 12'h801, 12'h800};
  int fails = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  serial_dac_load_interface serial_dac_load_interface_inst
  (
    .clk(clk),
    .arst_n(arst_n),
    .sclk(sclk),
    .serial_word_in(serial_word_in),
    .sync_n(sync_n),
    .latch_load_n(latch_load_n),
    .dac_code(dac_code),
    .dac_microvolt(dac_microvolt),
    .latch_update(latch_update),
    .auto_mode(auto_mode)
  );
  dac_host_model dac_host_model_inst
  (
    .sclk(sclk),
    .serial_word_in(serial_word_in),
    .sync_n(sync_n),
    .latch_load_n(latch_load_n)
  );
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(negedge clk)
    if (latch_update === 1'b1)
    begin
      if (q.size() == 0)
        `CHK(latch_update, 1'b0)
      else
      begin
        `CHK(dac_code, q[0][11:0])
        `CHK(auto_mode, q[0][12])
        `CHK(dac_microvolt, 32'($signed(q[0][11:0])) * 32'sd2441)
        void'(q.pop_front());
      end
    end
  initial
  begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(dac_code, 12'h000)
    `CHK(dac_microvolt, 32'h00000000)
    `CHK(latch_update, 1'b0)
    `CHK(auto_mode, 1'b0)
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr_next(rnd);
      c = i < 6 ? t[i] : rnd[11:0];
      if (i == 7)
        c = c ^ 12'h800;
      if (i != 6)
        q.push_back({!i[0], c});
      dac_host_model_inst.send({rnd[15:12], c}, i == 6 ? 10 : 16, i[0], i % 4);
      $display("test %0d done", i);
    end
    repeat (10) @(negedge clk);
    `CHK(q.size(), 0)
    report_and_stop();
  end
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule
